// [prc_defines.svh]
// Constants for the supply redundancy and protection controller.
// Notes on behaviour
// - Host sets one of five redundancy modes.
// - Standard mode releases line, pulls low on fault.
// - Cold active mode keeps main output on.
// - Standby positions wake in order with load.
// - Cold standby: power good high, green blink.
// - Line falling edge reverts standby modes to standard.
// - Host must rewrite mode after reversion.
// - Line high allows standby; low forces on.
// - Trips latch main output only; standby stays.
// - Overcurrent/overpower retries thrice, 3 s apart, latches.
// - Latch clears: enable high 1 s or 15 s power loss.
// - Auxiliary output recovers automatically without latching.
// - Throttle current raises alert within 20 us.
// - Fast alert held 100 ms then released.
// - Throttle threshold lies below overpower trip.
// - Overvoltage latches main off; peers unaffected.
// - Over-temperature stops main, restarts automatically.
// - Warning 63 C, critical 68 C, alert, indicator.
// - Green steady when good; blink when standby.
// - Amber on lost input while peer runs, or critical shutdown.
// - Address straps select bus address B0h..B6h.
// - Main output only while active-low enable low.
`ifndef PRC_DEFINES_SVH
`define PRC_DEFINES_SVH
// ****************************************************************
// Timing
// ****************************************************************
`define PRC_CLK_HZ 25000000
`define PRC_RETRY_MS 3000
`define PRC_ENCLR_MS 1000
`define PRC_PWRCLR_MS 15000
`define PRC_ALERT_HOLD_MS 100
`define PRC_FAST_ALERT_US 20
`define PRC_TEMP_ALERT_US 100
`define PRC_BLINK_HALF_MS 500
`define PRC_MS_CYC(ms) ((ms) * (`PRC_CLK_HZ / 1000))
`define PRC_RETRY_COUNT 3
// ****************************************************************
// Temperature thresholds and addresses
// ****************************************************************
`define PRC_TEMP_WARN 8'd63
`define PRC_TEMP_CRIT 8'd68
`define PRC_ADDR_BASE 8'hb0
// ****************************************************************
// Host register offsets (command port of the host end)
// ****************************************************************
`define PRC_REG_MODE 4'h0
`define PRC_REG_STATUS 4'h1
`define PRC_REG_ADDR 4'h2
`endif

// [prc_pkg.sv]
// Types shared by both ends of the redundancy controller.
package prc_pkg;
	typedef enum logic [2:0] {
		PRC_STANDARD = 3'h0,
		PRC_COLD_ACTIVE = 3'h1,
		PRC_STANDBY1 = 3'h2,
		PRC_STANDBY2 = 3'h3,
		PRC_STANDBY3 = 3'h4
	} prc_mode_t;
	typedef enum logic [1:0] {
		PRC_LED_OFF = 2'h0,
		PRC_LED_GREEN = 2'h1,
		PRC_LED_BLINK = 2'h2,
		PRC_LED_AMBER = 2'h3
	} prc_led_t;
endpackage

// [prc_link_if.sv]
// Link between the supply module and the host and peer side.
interface prc_link_if;
	import prc_pkg::*;
	logic modeWrite;
	prc_mode_t modeData;
	prc_mode_t modeReadback;
	logic enableMain_n;
	logic alertOut;
	logic alertOe;
	logic coldLineOut;
	logic coldLineOe;
	logic peerPullLow;
	logic cold_redundancy_line_n;
	logic alert_n;
	logic address_strap_low;
	logic address_strap_high;
	logic power_good_alias;
	assign cold_redundancy_line_n = !((coldLineOe && !coldLineOut) || peerPullLow);
	assign alert_n = !(alertOe && !alertOut);
	modport device (
		input modeWrite, modeData, enableMain_n, cold_redundancy_line_n,
		input address_strap_low, address_strap_high,
		output modeReadback, alertOut, alertOe, coldLineOut, coldLineOe, power_good_alias
	);
	modport host (
		output modeWrite, modeData, enableMain_n, peerPullLow,
		output address_strap_low, address_strap_high,
		input modeReadback, alert_n, cold_redundancy_line_n, power_good_alias
	);
endinterface

// [prc_host_end.sv]
// Host end: command registers that drive mode, enable and straps.
`include "prc_defines.svh"
module prc_host_end
	import prc_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [3:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	output logic [7:0] rdData,
	prc_link_if.host link
);
	logic [7:0] ctrl;
	// ****************************************************************
	// Command port
	// ****************************************************************
	// Mode writes become a one-cycle strobe toward the device.
	always_ff @(posedge mclk) begin
		if (reset) begin
			link.modeWrite <= 1'b0;
			link.modeData <= PRC_STANDARD;
		end else begin
			link.modeWrite <= wrStrobe && addr == `PRC_REG_MODE;
			if (wrStrobe && addr == `PRC_REG_MODE) begin
				link.modeData <= prc_mode_t'(wrData[2:0]);
			end
		end
	end
	// Control bits: bit0 enable low, bit1 peer pull, bits 3:2 straps.
	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrl <= 8'h01;
		end else if (wrStrobe && addr == `PRC_REG_STATUS) begin
			ctrl <= wrData;
		end
	end
	assign link.enableMain_n = ctrl[0];
	assign link.peerPullLow = ctrl[1];
	assign link.address_strap_low = ctrl[2];
	assign link.address_strap_high = ctrl[3];
	// Read data stands one cycle after the strobe.
	always_ff @(posedge mclk) begin
		if (reset) begin
			rdData <= 8'h00;
		end else if (rdStrobe) begin
			unique case (addr)
				`PRC_REG_MODE: rdData <= {5'h00, link.modeReadback};
				`PRC_REG_STATUS: rdData <= {ctrl[7:4], link.power_good_alias,
					!link.alert_n, link.cold_redundancy_line_n, 1'b0};
				default: rdData <= 8'h00;
			endcase
		end else begin
			rdData <= 8'h00;
		end
	end
endmodule

// [prc_device_end.sv]
// Device end: redundancy mode, protection latches, alert and indicator.
//
// Local design decisions: the address-and-strobe port and the address map.
`include "prc_defines.svh"
module prc_device_end
	import prc_pkg::*;
#(
	parameter int RETRY_CYC = `PRC_MS_CYC(`PRC_RETRY_MS),
	parameter int ENCLR_CYC = `PRC_MS_CYC(`PRC_ENCLR_MS),
	parameter int PWRCLR_CYC = `PRC_MS_CYC(`PRC_PWRCLR_MS),
	parameter int ALERT_CYC = `PRC_MS_CYC(`PRC_ALERT_HOLD_MS),
	parameter int BLINK_CYC = `PRC_MS_CYC(`PRC_BLINK_HALF_MS)
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic inputPowerOk,
	input wire logic peerRunning,
	input wire logic loadStep1,
	input wire logic loadStep2,
	input wire logic loadStep3,
	input wire logic overCurrent,
	input wire logic overPower,
	input wire logic overVoltage,
	input wire logic auxFault,
	input wire logic throttleCurrent,
	input wire logic fanFail,
	input wire logic [7:0] ambientTemp,
	output logic mainOn,
	output logic auxOn,
	output prc_led_t ledState,
	output logic [7:0] busAddress,
	output logic tempWarn,
	output logic tempCrit,
	prc_link_if.device link
);
	prc_mode_t mode;
	logic linePrev;
	logic protLatch;
	logic [1:0] retries;
	logic retryWait;
	logic [31:0] retryCnt;
	logic [31:0] enHighCnt;
	logic [31:0] pwrLossCnt;
	logic [31:0] alertCnt;
	logic [31:0] blinkCnt;
	logic blink;
	logic inStandby;
	logic wantMain;
	logic ocTrip;
	logic latchClear;
	logic overTemp;
	assign ocTrip = (overCurrent || overPower) && mainOn;
	assign overTemp = ambientTemp >= `PRC_TEMP_CRIT;
	// The latch clears after a second of enable high or long power loss.
	assign latchClear = (enHighCnt >= ENCLR_CYC - 1) || (pwrLossCnt >= PWRCLR_CYC - 1);
	// Standby units sleep while the line is high and the load is below their step.
	always_comb begin
		unique case (mode)
			PRC_STANDBY1: inStandby = link.cold_redundancy_line_n && !loadStep1;
			PRC_STANDBY2: inStandby = link.cold_redundancy_line_n && !loadStep2;
			PRC_STANDBY3: inStandby = link.cold_redundancy_line_n && !loadStep3;
			default: inStandby = 1'b0;
		endcase
	end
	assign wantMain = !link.enableMain_n && inputPowerOk && !protLatch && !retryWait
		&& !overVoltage && !overTemp && !inStandby;
	// ****************************************************************
	// Redundancy mode
	// ****************************************************************
	// A falling line edge wins over a simultaneous host write.
	always_ff @(posedge mclk) begin
		if (reset) begin
			mode <= PRC_STANDARD;
			linePrev <= 1'b1;
		end else begin
			linePrev <= link.cold_redundancy_line_n;
			if (linePrev && !link.cold_redundancy_line_n &&
					(mode == PRC_STANDBY1 || mode == PRC_STANDBY2 || mode == PRC_STANDBY3)) begin
				mode <= PRC_STANDARD;
			end else if (link.modeWrite && link.modeData <= PRC_STANDBY3) begin
				mode <= link.modeData;
			end
		end
	end
	// Only standard mode pulls the line, and only on a fault.
	always_ff @(posedge mclk) begin
		if (reset) begin
			link.coldLineOe <= 1'b0;
		end else begin
			link.coldLineOe <= mode == PRC_STANDARD &&
				(protLatch || retryWait || overVoltage || overTemp);
		end
	end
	assign link.coldLineOut = 1'b0;
	assign link.modeReadback = mode;
	// ****************************************************************
	// Protection
	// ****************************************************************
	// Overcurrent retries with a hold-off; the fourth trip latches.
	always_ff @(posedge mclk) begin
		if (reset) begin
			protLatch <= 1'b0;
			retries <= 2'd0;
			retryWait <= 1'b0;
			retryCnt <= 32'd0;
		end else if (latchClear) begin
			protLatch <= 1'b0;
			retries <= 2'd0;
			retryWait <= 1'b0;
			retryCnt <= 32'd0;
		end else if (overVoltage && mainOn) begin
			protLatch <= 1'b1;
		end else if (ocTrip) begin
			if (retries == 2'(`PRC_RETRY_COUNT)) begin
				protLatch <= 1'b1;
			end else begin
				retries <= retries + 2'd1;
				retryWait <= 1'b1;
				retryCnt <= 32'd0;
			end
		end else if (retryWait) begin
			retryCnt <= retryCnt + 32'd1;
			if (retryCnt >= RETRY_CYC - 1) begin
				retryWait <= 1'b0;
			end
		end
	end
	// Counters for enable held high and for input power absent.
	always_ff @(posedge mclk) begin
		if (reset) begin
			enHighCnt <= 32'd0;
			pwrLossCnt <= 32'd0;
		end else begin
			enHighCnt <= (link.enableMain_n && protLatch) ? enHighCnt + 32'd1 : 32'd0;
			pwrLossCnt <= (!inputPowerOk && protLatch) ? pwrLossCnt + 32'd1 : 32'd0;
		end
	end
	// Outputs; the auxiliary rail depends only on input power and its own fault.
	always_ff @(posedge mclk) begin
		if (reset) begin
			mainOn <= 1'b0;
			auxOn <= 1'b0;
			link.power_good_alias <= 1'b0;
		end else begin
			mainOn <= wantMain && !ocTrip;
			auxOn <= inputPowerOk && !auxFault;
			// Good is held through a wake from standby so the host never sees a dip.
			link.power_good_alias <= (wantMain && (mainOn || link.power_good_alias))
				|| inStandby;
		end
	end
	// ****************************************************************
	// Alert, temperature and indicator
	// ****************************************************************
	// Throttle current starts a hold; the next cycle drives the line.
	always_ff @(posedge mclk) begin
		if (reset) begin
			alertCnt <= 32'd0;
			link.alertOe <= 1'b0;
			tempWarn <= 1'b0;
			tempCrit <= 1'b0;
		end else begin
			tempWarn <= ambientTemp >= `PRC_TEMP_WARN;
			tempCrit <= overTemp;
			if (throttleCurrent) begin
				alertCnt <= 32'(ALERT_CYC);
			end else if (alertCnt != 32'd0) begin
				alertCnt <= alertCnt - 32'd1;
			end
			link.alertOe <= throttleCurrent || alertCnt > 32'd1 || tempWarn || tempCrit;
		end
	end
	assign link.alertOut = 1'b0;
	// Blink at one hertz, half period each phase.
	always_ff @(posedge mclk) begin
		if (reset) begin
			blinkCnt <= 32'd0;
			blink <= 1'b0;
		end else if (blinkCnt >= BLINK_CYC - 1) begin
			blinkCnt <= 32'd0;
			blink <= !blink;
		end else begin
			blinkCnt <= blinkCnt + 32'd1;
		end
	end
	// Amber beats steady green, steady green beats blink.
	always_ff @(posedge mclk) begin
		if (reset) begin
			ledState <= PRC_LED_OFF;
		end else if ((!inputPowerOk && peerRunning) || protLatch || fanFail || overTemp) begin
			ledState <= PRC_LED_AMBER;
		end else if (mainOn) begin
			ledState <= PRC_LED_GREEN;
		end else if (auxOn || inStandby) begin
			ledState <= blink ? PRC_LED_GREEN : PRC_LED_OFF;
		end else begin
			ledState <= PRC_LED_OFF;
		end
	end
	// Straps pick the management address, two apart per slot.
	always_ff @(posedge mclk) begin
		if (reset) begin
			busAddress <= `PRC_ADDR_BASE;
		end else begin
			busAddress <= `PRC_ADDR_BASE +
				{5'h00, link.address_strap_high, link.address_strap_low, 1'b0};
		end
	end
endmodule

// [prc_checker.sv]
// Concurrent checks on the link between the two controller ends.
module prc_checker
	import prc_pkg::*;
#(
	parameter int ALERT_CYC = 8
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic modeWrite,
	input wire prc_mode_t modeData,
	input wire prc_mode_t modeReadback,
	input wire logic enableMain_n,
	input wire logic coldLineOut,
	input wire logic coldLineOe,
	input wire logic cold_redundancy_line_n,
	input wire logic alert_n,
	input wire logic power_good_alias
);
	logic [7:0] lowCnt;
	logic stby;
	logic lineOk;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (reset);
	// Short names keep the properties on one line each.
	assign stby = modeReadback inside {PRC_STANDBY1, PRC_STANDBY2, PRC_STANDBY3};
	assign lineOk = cold_redundancy_line_n;
	// Alert low length; it saturates so a stuck alert never wraps to a short count.
	always_ff @(posedge mclk) begin
		if (reset || alert_n) begin
			lowCnt <= 8'h00;
		end else if (lowCnt != 8'hff) begin
			lowCnt <= lowCnt + 8'h01;
		end
	end
	// ********************
	// Properties
	// ********************
	property p_modeTake;
		modeWrite && modeData <= PRC_STANDBY3 && lineOk |=> modeReadback == $past(modeData);
	endproperty
	a_modeTake: assert property (p_modeTake) else $error("mode write lost");
	property p_badMode;
		modeWrite && modeData > PRC_STANDBY3 && lineOk |=> $stable(modeReadback);
	endproperty
	a_badMode: assert property (p_badMode) else $error("bad mode taken");
	property p_revert;
		$fell(lineOk) && stby |-> ##[1:2] modeReadback == PRC_STANDARD;
	endproperty
	a_revert: assert property (p_revert) else $error("standby kept");
	property p_noPull;
		modeReadback != PRC_STANDARD && $past(modeReadback) != PRC_STANDARD |-> !(coldLineOe && !coldLineOut);
	endproperty
	a_noPull: assert property (p_noPull) else $error("line pulled");
	property p_alertHold;
		$rose(alert_n) |-> lowCnt >= ALERT_CYC;
	endproperty
	a_alertHold: assert property (p_alertHold) else $error("alert short");
	property p_pgStandby;
		(stby && lineOk && !enableMain_n)[*4] |-> power_good_alias;
	endproperty
	a_pgStandby: assert property (p_pgStandby) else $error("standby good low");
	property p_offPg;
		(enableMain_n && modeReadback == PRC_STANDARD)[*4] |-> !power_good_alias;
	endproperty
	a_offPg: assert property (p_offPg) else $error("good while off");
	property p_modeHold;
		(lineOk && !modeWrite)[*3] |-> $stable(modeReadback);
	endproperty
	a_modeHold: assert property (p_modeHold) else $error("mode moved");
	c_revert: cover property ($fell(lineOk) && stby);
	c_alert: cover property ($rose(alert_n));
	c_badMode: cover property (modeWrite && modeData > PRC_STANDBY3);
endmodule

// [test_psu_redundancy_protection_ctrl.sv]
// Bench for the host and device ends joined by the link.
`include "prc_defines.svh"
module test_psu_redundancy_protection_ctrl import prc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int RETRY_CYC = 20;
	localparam int ENCLR_CYC = 10;
	localparam int PWRCLR_CYC = 30;
	localparam int ALERT_CYC = 8;
	localparam int BLINK_CYC = 4;
	localparam logic [3:0] MODE = `PRC_REG_MODE;
	localparam logic [3:0] CTRL = `PRC_REG_STATUS;
	logic mclk = 1'h0;
	logic reset = 1'h1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wrData = 8'h00;
	logic wrStrobe = 1'h0, rdStrobe = 1'h0, rdPend = 1'h0;
	logic inputPowerOk = 1'h1, peerRunning = 1'h0, auxFault = 1'h0, fanFail = 1'h0;
	logic overCurrent = 1'h0, overPower = 1'h0, overVoltage = 1'h0, throttleCurrent = 1'h0;
	logic [3:1] loadStep = 3'h0;
	logic [7:0] ambientTemp = 8'h19;
	logic [7:0] rdData, busAddress;
	logic mainOn, auxOn, tempWarn, tempCrit;
	prc_led_t ledState;
	logic [7:0] expQ[$];
	logic [7:0] temps[4] = '{8'h3e, 8'h3f, 8'h43, 8'h44};
	int nErrors = 0, comparisons = 0, n;
	integer seed = 32'h59c182e1;
	logic [31:0] v;
	prc_link_if link();
	prc_host_end prc_host_end_i (.mclk, .reset, .addr, .wrData, .wrStrobe, .rdStrobe,
		.rdData, .link);
	prc_device_end #(.RETRY_CYC(RETRY_CYC), .ENCLR_CYC(ENCLR_CYC), .PWRCLR_CYC(PWRCLR_CYC),
		.ALERT_CYC(ALERT_CYC), .BLINK_CYC(BLINK_CYC)) prc_device_end_i (.mclk, .reset,
		.inputPowerOk, .peerRunning, .loadStep1(loadStep[1]), .loadStep2(loadStep[2]),
		.loadStep3(loadStep[3]), .overCurrent, .overPower, .overVoltage, .auxFault,
		.throttleCurrent, .fanFail, .ambientTemp, .mainOn, .auxOn, .ledState, .busAddress,
		.tempWarn, .tempCrit, .link);
	prc_checker #(.ALERT_CYC(ALERT_CYC)) prc_checker_i (.mclk, .reset,
		.modeWrite(link.modeWrite), .modeData(link.modeData), .modeReadback(link.modeReadback),
		.enableMain_n(link.enableMain_n), .coldLineOut(link.coldLineOut),
		.coldLineOe(link.coldLineOe), .cold_redundancy_line_n(link.cold_redundancy_line_n),
		.alert_n(link.alert_n), .power_good_alias(link.power_good_alias));
	// ********************
	// Tasks
	// ********************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			nErrors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge mclk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'h1;
		@(posedge mclk);
		wrStrobe <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk);
		expQ.push_back(e);
		addr <= a;
		rdStrobe <= 1'h1;
		@(posedge mclk);
		rdStrobe <= 1'h0;
	endtask
	// Counts restarts of the main output over a window of cycles.
	task automatic rises(input int c, output int r);
		logic p;
		r = 0;
		p = mainOn;
		repeat (c) begin
			@(posedge mclk);
			r += (mainOn && !p);
			p = mainOn;
		end
	endtask
	// Enable held off longer than the clear count, then on again.
	task automatic clearByEnable();
		wr(CTRL, 8'h01);
		tick(ENCLR_CYC + 4);
		wr(CTRL, 8'h00);
		tick(6);
		chk(mainOn, 1'h1);
	endtask
	task automatic end_of_test();
		$display("Mismatches %0d, comparisons %0d", nErrors, comparisons);
		if (nErrors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ********************
	// Processes
	// ********************
	always #20 mclk = ~mclk;
	// Read data stands only in the cycle after the strobe, so it is taken there.
	always @(posedge mclk) begin
		if (rdPend)
			chk(rdData, expQ.pop_front());
		rdPend <= rdStrobe;
	end
	// A hang ends the run through the normal closing path.
	initial begin
		repeat (5000) @(posedge mclk);
		nErrors++;
		end_of_test();
	end
	// Reset, then every scenario in turn.
	initial begin
		repeat (5) @(posedge mclk);
		reset <= 1'h0;
		wait (!reset);
		rd(MODE, 8'h00);
		rd(CTRL, 8'h02);
		rd(4'hf, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(CTRL, 8'({i[1:0], 2'h1}));
			tick(3);
			chk(busAddress, 8'hb0 + 8'(2 * i));
		end
		wr(CTRL, 8'h00);
		tick(6);
		chk(mainOn, 1'h1);
		chk(ledState, PRC_LED_GREEN);
		rd(CTRL, 8'h0a);
		for (int m = 0; m < 5; m++) begin
			wr(MODE, 8'(m));
			rd(MODE, 8'(m));
		end
		wr(MODE, 8'h07);
		rd(MODE, 8'h04);
		for (int k = 1; k < 4; k++) begin
			wr(MODE, 8'(k + 1));
			tick(4);
			chk(mainOn, 1'h0);
			chk(link.power_good_alias, 1'h1);
			n = 0;
			repeat (2 * BLINK_CYC) begin
				@(posedge mclk);
				n += (ledState === PRC_LED_GREEN);
			end
			chk(8'(n), 8'(BLINK_CYC));
			loadStep[k] <= 1'h1;
			tick(4);
			chk(mainOn, 1'h1);
			loadStep <= 3'h0;
		end
		tick(4);
		wr(CTRL, 8'h02);
		tick(4);
		chk(mainOn, 1'h1);
		rd(MODE, 8'h00);
		wr(CTRL, 8'h00);
		tick(3);
		rd(MODE, 8'h00);
		@(posedge mclk) throttleCurrent <= 1'h1;
		@(posedge mclk) throttleCurrent <= 1'h0;
		tick(2);
		chk(link.alert_n, 1'h0);
		tick(ALERT_CYC + 3);
		chk(link.alert_n, 1'h1);
		overCurrent <= 1'h1;
		rises(5 * RETRY_CYC, n);
		chk(8'(n), 8'h03);
		overCurrent <= 1'h0;
		tick(2 * RETRY_CYC);
		chk(mainOn, 1'h0);
		chk(auxOn, 1'h1);
		chk(ledState, PRC_LED_AMBER);
		chk(link.cold_redundancy_line_n, 1'h0);
		clearByEnable();
		throttleCurrent <= 1'h1;
		overPower <= 1'h1;
		rises(5 * RETRY_CYC, n);
		chk(8'(n), 8'h03);
		chk(link.alert_n, 1'h0);
		overPower <= 1'h0;
		throttleCurrent <= 1'h0;
		inputPowerOk <= 1'h0;
		peerRunning <= 1'h1;
		tick(4);
		chk(ledState, PRC_LED_AMBER);
		tick(PWRCLR_CYC);
		inputPowerOk <= 1'h1;
		tick(6);
		chk(mainOn, 1'h1);
		@(posedge mclk) overVoltage <= 1'h1;
		@(posedge mclk) overVoltage <= 1'h0;
		tick(RETRY_CYC + 5);
		chk(mainOn, 1'h0);
		clearByEnable();
		foreach (temps[j]) begin
			ambientTemp <= temps[j];
			tick(6);
			chk(tempCrit, temps[j] >= 8'h44);
			if (temps[j] < 8'h44)
				chk(tempWarn, temps[j] >= 8'h3f);
		end
		chk(mainOn, 1'h0);
		chk(auxOn, 1'h1);
		ambientTemp <= 8'h19;
		tick(6);
		chk(mainOn, 1'h1);
		repeat (6) begin
			v = $random(seed);
			ambientTemp <= {2'h0, v[5:0]};
			tick(ALERT_CYC + 2);
			chk(tempWarn, v[5:0] == 6'h3f);
		end
		auxFault <= 1'h1;
		tick(3);
		chk(auxOn, 1'h0);
		chk(mainOn, 1'h1);
		auxFault <= 1'h0;
		tick(3);
		chk(auxOn, 1'h1);
		fanFail <= 1'h1;
		tick(4);
		chk(ledState, PRC_LED_AMBER);
		tick(2);
		end_of_test();
	end
endmodule
